// ### logic/ptq_pkg.sv
// Constants and types for the package trigger qualifier
// What this block does
// - Four modes selectable: photoeye, curtain, curtain plus photoeye, serial; serial mode never triggers.
// - Photoeye mode: presence from the photoeye only, no height use.
// - Curtain mode: presence and height both come from the curtain.
// - Combined mode: photoeye gives presence, curtain gives height for focus.
// - Package longer than the maximum length flags an error and counts it.
// - Trigger accepted only after staying active for the debounce travel.
// - Polarity setting makes the photoeye active low, else active high.
// - Photoeye to scan line distance is held and times the scan.
// - Photoeye mode ignores curtain settings; curtain mode ignores photoeye settings.
// - Signed mounting offset is added to curtain height for actual height.
// - Packages below the minimum height are not scanned.
// - Curtain to scan line distance is held and times curtain scans.
// - Belt travel is measured by counting tach pulses at set resolution.
package ptq_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RES = 8'h04;
    localparam logic [7:0] ADDR_DEBOUNCE = 8'h08;
    localparam logic [7:0] ADDR_MAX_LEN = 8'h0C;
    localparam logic [7:0] ADDR_PE_SCAN = 8'h10;
    localparam logic [7:0] ADDR_LC_SCAN = 8'h14;
    localparam logic [7:0] ADDR_LC_OFFSET = 8'h18;
    localparam logic [7:0] ADDR_MIN_HEIGHT = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_HEIGHT = 8'h24;
    localparam logic [7:0] ADDR_TOO_LONG_CNT = 8'h28;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h2C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h30;

    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACTIVE_LOW_BIT = 2;
    localparam int IRQ_ACCEPT_BIT = 0;
    localparam int IRQ_TOO_LONG_BIT = 1;
    localparam int IRQ_SCAN_BIT = 2;
    localparam int IRQ_SUPPRESS_BIT = 3;
    localparam int IRQ_W = 4;

    // Widths
    localparam int DIST_W = 16;
    localparam int RES_W = 11;
    localparam int THR_W = 32;
    localparam int HEIGHT_W = 16;
    localparam int CNT_W = 16;

    // Distances are hundredths of an inch, resolution is tenths of a PPI;
    // each tach pulse is worth this many (hundredth-inch x tenth-PPI) units
    localparam logic [THR_W-1:0] TRAVEL_STEP = 32'h0000_03E8;

    // Reset values
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [RES_W-1:0] RST_RES = 11'h064;
    localparam logic [DIST_W-1:0] RST_DEBOUNCE = 16'h0000;
    localparam logic [DIST_W-1:0] RST_MAX_LEN = 16'h1770;
    localparam logic [DIST_W-1:0] RST_PE_SCAN = 16'h0000;
    localparam logic [DIST_W-1:0] RST_LC_SCAN = 16'h0064;
    localparam logic [DIST_W-1:0] RST_LC_OFFSET = 16'h0000;
    localparam logic [DIST_W-1:0] RST_MIN_HEIGHT = 16'h0032;

    typedef enum logic [1:0] {
        MODE_PHOTOEYE,
        MODE_CURTAIN,
        MODE_BOTH,
        MODE_SERIAL
    } ptq_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DEBOUNCE,
        ST_PACKAGE
    } ptq_state_e;
endpackage

// ### logic/ptq_sync.sv
// Two-stage synchroniser for a group of sensor pins
`timescale 1ns/1ps
module ptq_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Pins and synchronised copy
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// ### logic/ptq_top.sv
// Package trigger qualifier: sensor qualify, debounce, length, scan timing
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module ptq_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Sensor pins
    input wire logic presence_sensor_i,
    input wire logic curtain_blocked_i,
    input wire logic [15:0] curtain_height_i,
    input wire logic tach_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [31:0] reg_rdata_o,
    // Results
    output logic scan_trigger_o,
    output logic package_present_o,
    output logic too_long_o,
    output logic [15:0] package_height_o,
    output logic irq_o
);
    localparam int SYNC_W = ptq_pkg::HEIGHT_W + 3;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [SYNC_W-1:0] pins_s;
    logic pe_s;
    logic lc_s;
    logic tach_s;
    logic [ptq_pkg::HEIGHT_W-1:0] height_s;
    logic tach_prev_q;
    logic tach_pulse;

    ptq_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({curtain_height_i, tach_i, curtain_blocked_i,
                presence_sensor_i}),
        .sync_o(pins_s)
    );

    assign pe_s = pins_s[0];
    assign lc_s = pins_s[1];
    assign tach_s = pins_s[2];
    assign height_s = pins_s[SYNC_W-1:3];
    assign tach_pulse = tach_s & ~tach_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [1:0] mode_q, mode_d;
    logic active_low_q, active_low_d;
    logic [ptq_pkg::RES_W-1:0] res_q, res_d;
    logic [ptq_pkg::DIST_W-1:0] deb_q, deb_d;
    logic [ptq_pkg::DIST_W-1:0] max_len_q, max_len_d;
    logic [ptq_pkg::DIST_W-1:0] pe_scan_q, pe_scan_d;
    logic [ptq_pkg::DIST_W-1:0] lc_scan_q, lc_scan_d;
    logic [ptq_pkg::DIST_W-1:0] lc_off_q, lc_off_d;
    logic [ptq_pkg::DIST_W-1:0] min_h_q, min_h_d;
    logic [ptq_pkg::IRQ_W-1:0] irq_st_q, irq_st_d;
    logic [ptq_pkg::IRQ_W-1:0] irq_mask_q, irq_mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic [ptq_pkg::IRQ_W-1:0] irq_events;
    logic [ptq_pkg::CNT_W-1:0] too_long_cnt_q;
    logic [ptq_pkg::HEIGHT_W-1:0] height_q;
    logic busy_q;
    logic scan_pend_q;

    always_comb begin
        mode_d = mode_q;
        active_low_d = active_low_q;
        res_d = res_q;
        deb_d = deb_q;
        max_len_d = max_len_q;
        pe_scan_d = pe_scan_q;
        lc_scan_d = lc_scan_q;
        lc_off_d = lc_off_q;
        min_h_d = min_h_q;
        irq_mask_d = irq_mask_q;
        // Hardware set wins over a write-one clear in the same cycle
        irq_st_d = irq_st_q | irq_events;
        rdata_d = '0;
        if (reg_we_i) begin
            unique case (reg_addr_i)
                ptq_pkg::ADDR_CTRL: begin
                    mode_d = reg_wdata_i[ptq_pkg::CTRL_MODE_LSB +: 2];
                    active_low_d = reg_wdata_i[ptq_pkg::CTRL_ACTIVE_LOW_BIT];
                end
                ptq_pkg::ADDR_RES: res_d = reg_wdata_i[ptq_pkg::RES_W-1:0];
                ptq_pkg::ADDR_DEBOUNCE:
                    deb_d = reg_wdata_i[ptq_pkg::DIST_W-1:0];
                ptq_pkg::ADDR_MAX_LEN:
                    max_len_d = reg_wdata_i[ptq_pkg::DIST_W-1:0];
                ptq_pkg::ADDR_PE_SCAN:
                    pe_scan_d = reg_wdata_i[ptq_pkg::DIST_W-1:0];
                ptq_pkg::ADDR_LC_SCAN:
                    lc_scan_d = reg_wdata_i[ptq_pkg::DIST_W-1:0];
                ptq_pkg::ADDR_LC_OFFSET:
                    lc_off_d = reg_wdata_i[ptq_pkg::DIST_W-1:0];
                ptq_pkg::ADDR_MIN_HEIGHT:
                    min_h_d = reg_wdata_i[ptq_pkg::DIST_W-1:0];
                ptq_pkg::ADDR_IRQ_STATUS:
                    irq_st_d = (irq_st_q & ~reg_wdata_i[ptq_pkg::IRQ_W-1:0])
                        | irq_events;
                ptq_pkg::ADDR_IRQ_MASK:
                    irq_mask_d = reg_wdata_i[ptq_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        if (reg_re_i) begin
            unique case (reg_addr_i)
                ptq_pkg::ADDR_CTRL:
                    rdata_d = {29'h0, active_low_q, mode_q};
                ptq_pkg::ADDR_RES: rdata_d = {21'h0, res_q};
                ptq_pkg::ADDR_DEBOUNCE: rdata_d = {16'h0, deb_q};
                ptq_pkg::ADDR_MAX_LEN: rdata_d = {16'h0, max_len_q};
                ptq_pkg::ADDR_PE_SCAN: rdata_d = {16'h0, pe_scan_q};
                ptq_pkg::ADDR_LC_SCAN: rdata_d = {16'h0, lc_scan_q};
                ptq_pkg::ADDR_LC_OFFSET: rdata_d = {16'h0, lc_off_q};
                ptq_pkg::ADDR_MIN_HEIGHT: rdata_d = {16'h0, min_h_q};
                ptq_pkg::ADDR_STATUS:
                    rdata_d = {28'h0, scan_pend_q, too_long_o, busy_q,
                               package_present_o};
                ptq_pkg::ADDR_HEIGHT: rdata_d = {16'h0, height_q};
                ptq_pkg::ADDR_TOO_LONG_CNT: rdata_d = {16'h0, too_long_cnt_q};
                ptq_pkg::ADDR_IRQ_STATUS: rdata_d = {28'h0, irq_st_q};
                ptq_pkg::ADDR_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= ptq_pkg::RST_MODE;
            active_low_q <= 1'b0;
            res_q <= ptq_pkg::RST_RES;
            deb_q <= ptq_pkg::RST_DEBOUNCE;
            max_len_q <= ptq_pkg::RST_MAX_LEN;
            pe_scan_q <= ptq_pkg::RST_PE_SCAN;
            lc_scan_q <= ptq_pkg::RST_LC_SCAN;
            lc_off_q <= ptq_pkg::RST_LC_OFFSET;
            min_h_q <= ptq_pkg::RST_MIN_HEIGHT;
            irq_st_q <= '0;
            irq_mask_q <= '0;
            rdata_q <= '0;
        end else begin
            mode_q <= mode_d;
            active_low_q <= active_low_d;
            res_q <= res_d;
            deb_q <= deb_d;
            max_len_q <= max_len_d;
            pe_scan_q <= pe_scan_d;
            lc_scan_q <= lc_scan_d;
            lc_off_q <= lc_off_d;
            min_h_q <= min_h_d;
            irq_st_q <= irq_st_d;
            irq_mask_q <= irq_mask_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_o = |(irq_st_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // Source selection, polarity and height correction

    ptq_pkg::ptq_mode_e mode;
    logic use_curtain_h;
    logic raw_active;
    logic signed [ptq_pkg::HEIGHT_W+1:0] height_sum;
    logic [ptq_pkg::HEIGHT_W-1:0] height_adj;
    logic [ptq_pkg::THR_W-1:0] deb_thr;
    logic [ptq_pkg::THR_W-1:0] len_thr;
    logic [ptq_pkg::THR_W-1:0] scan_thr;

    assign mode = ptq_pkg::ptq_mode_e'(mode_q);
    // curtain settings only in curtain modes
    assign use_curtain_h = (mode == ptq_pkg::MODE_CURTAIN) ||
        (mode == ptq_pkg::MODE_BOTH);

    always_comb begin
        unique case (mode)
            ptq_pkg::MODE_PHOTOEYE: raw_active = pe_s ^ active_low_q;
            ptq_pkg::MODE_CURTAIN: raw_active = lc_s;
            ptq_pkg::MODE_BOTH: raw_active = pe_s ^ active_low_q;
            default: raw_active = 1'b0;
        endcase
    end

    // signed offset added, clamped at zero
    assign height_sum = $signed({2'b00, height_s}) +
        $signed({{2{lc_off_q[ptq_pkg::DIST_W-1]}}, lc_off_q});
    assign height_adj = height_sum[ptq_pkg::HEIGHT_W+1] ? '0 :
        (height_sum[ptq_pkg::HEIGHT_W] ? '1 :
         height_sum[ptq_pkg::HEIGHT_W-1:0]);

    assign deb_thr = ptq_pkg::THR_W'(deb_q * res_q);
    assign len_thr = ptq_pkg::THR_W'(max_len_q * res_q);
    assign scan_thr = (mode == ptq_pkg::MODE_CURTAIN) ?
        ptq_pkg::THR_W'(lc_scan_q * res_q) :
        ptq_pkg::THR_W'(pe_scan_q * res_q);

    ////////////////////////////////////////////////////////////////////////
    // Trigger qualification, length and scan timing

    ptq_pkg::ptq_state_e state_q, state_d;
    logic [ptq_pkg::THR_W-1:0] travel_q, travel_d;
    logic [ptq_pkg::THR_W-1:0] scan_cnt_q, scan_cnt_d;
    logic [ptq_pkg::THR_W-1:0] step;
    logic scan_pend_d;
    logic too_long_q, too_long_d;
    logic [ptq_pkg::CNT_W-1:0] too_long_cnt_d;
    logic [ptq_pkg::HEIGHT_W-1:0] height_d;
    logic scan_q, scan_d;
    logic ev_accept, ev_too_long, ev_suppress;

    // one tach pulse is one step of travel
    assign step = tach_pulse ? ptq_pkg::TRAVEL_STEP : '0;

    always_comb begin
        state_d = state_q;
        travel_d = travel_q;
        scan_cnt_d = scan_cnt_q;
        scan_pend_d = scan_pend_q;
        too_long_d = too_long_q;
        too_long_cnt_d = too_long_cnt_q;
        height_d = height_q;
        scan_d = 1'b0;
        ev_accept = 1'b0;
        ev_too_long = 1'b0;
        ev_suppress = 1'b0;
        unique case (state_q)
            ptq_pkg::ST_IDLE: begin
                travel_d = '0;
                if (raw_active) begin
                    state_d = ptq_pkg::ST_DEBOUNCE;
                end
            end
            ptq_pkg::ST_DEBOUNCE: begin
                if (!raw_active) begin
                    state_d = ptq_pkg::ST_IDLE;
                end else if (travel_q >= deb_thr) begin
                    state_d = ptq_pkg::ST_PACKAGE;
                    ev_accept = 1'b1;
                    too_long_d = 1'b0;
                    height_d = '0;
                    scan_pend_d = 1'b1;
                    scan_cnt_d = '0;
                end else begin
                    travel_d = travel_q + step;
                end
            end
            ptq_pkg::ST_PACKAGE: begin
                travel_d = travel_q + step;
                if (use_curtain_h && height_adj > height_q) begin
                    height_d = height_adj;
                end
                if (!too_long_q && travel_q > len_thr) begin
                    too_long_d = 1'b1;
                    ev_too_long = 1'b1;
                    too_long_cnt_d = too_long_cnt_q + 1'b1;
                end
                if (!raw_active) begin
                    state_d = ptq_pkg::ST_IDLE;
                end
            end
            default: state_d = ptq_pkg::ST_IDLE;
        endcase
        if (scan_pend_q && !ev_accept) begin
            if (scan_cnt_q >= scan_thr) begin
                scan_pend_d = 1'b0;
                if (use_curtain_h && height_d < min_h_q) begin
                    ev_suppress = 1'b1;
                end else begin
                    scan_d = 1'b1;
                end
            end else begin
                scan_cnt_d = scan_cnt_q + step;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ptq_pkg::ST_IDLE;
            travel_q <= '0;
            scan_cnt_q <= '0;
            scan_pend_q <= 1'b0;
            too_long_q <= 1'b0;
            too_long_cnt_q <= '0;
            height_q <= '0;
            scan_q <= 1'b0;
            tach_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            travel_q <= travel_d;
            scan_cnt_q <= scan_cnt_d;
            scan_pend_q <= scan_pend_d;
            too_long_q <= too_long_d;
            too_long_cnt_q <= too_long_cnt_d;
            height_q <= height_d;
            scan_q <= scan_d;
            tach_prev_q <= tach_s;
        end
    end

    assign busy_q = (state_q != ptq_pkg::ST_IDLE);
    assign package_present_o = (state_q == ptq_pkg::ST_PACKAGE);
    assign too_long_o = too_long_q;
    assign package_height_o = height_q;
    assign scan_trigger_o = scan_q;
    assign irq_events = {ev_suppress, scan_d, ev_too_long, ev_accept};
endmodule

// ### verification/ptq_sensor_model.sv
// Photoeye, light curtain and tach encoder seen by the qualifier
`timescale 1ns/1ps
module ptq_sensor_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Scene control
    input wire logic pkg_i,
    input wire logic act_low_i,
    input wire logic tach_en_i,
    input wire logic [15:0] hgt_i,
    // Sensor pins
    output logic presence_o,
    output logic blocked_o,
    output logic tach_o,
    output logic [15:0] height_o
);
    logic [2:0] ph_q;
    logic [2:0] ph_d;
    assign presence_o = pkg_i ^ act_low_i;
    assign blocked_o = pkg_i;
    assign height_o = pkg_i ? hgt_i : 16'h0000;
    // Tach pulse every 8 clocks while the belt runs
    always_comb begin
        ph_d = tach_en_i ? ph_q + 3'h1 : ph_q;
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_q <= 3'h0;
        end else begin
            ph_q <= ph_d;
        end
    end
    assign tach_o = ph_q[2];
endmodule

// ### verification/ptq_checker.sv
// Port assertions for the package trigger qualifier
`timescale 1ns/1ps
module ptq_checker (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Sensor pins
    input wire logic presence_sensor_i,
    input wire logic curtain_blocked_i,
    input wire logic [15:0] curtain_height_i,
    input wire logic tach_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [31:0] reg_rdata_o,
    // Results
    input wire logic scan_trigger_o,
    input wire logic package_present_o,
    input wire logic too_long_o,
    input wire logic [15:0] package_height_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // Clocks since the last tach rising edge, saturating
    logic tach_q;
    logic tach_d;
    logic [3:0] since_q;
    logic [3:0] since_d;
    always_comb begin
        tach_d = tach_i;
        since_d = (since_q == 4'hF) ? since_q : since_q + 4'h1;
        if (tach_i && !tach_q) begin
            since_d = 4'h0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tach_q <= 1'h0;
            since_q <= 4'hF;
        end else begin
            tach_q <= tach_d;
            since_q <= since_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    scan_pulse_a: assert property (
        scan_trigger_o |=> !scan_trigger_o)
        else $error("scan trigger longer than one cycle");
    scan_gap_a: assert property (
        $rose(package_present_o) |-> !scan_trigger_o)
        else $error("scan fired too soon after accept");
    rd_quiet_a: assert property (
        !reg_re_i |=> reg_rdata_o == 32'h0)
        else $error("read data without a read");
    irq_fall_a: assert property (
        $fell(irq_o) |-> $past(reg_we_i) || $past(reg_we_i, 2))
        else $error("interrupt dropped without a write");
    long_in_pkg_a: assert property (
        $rose(too_long_o) |-> package_present_o)
        else $error("too long outside a package");
    long_hold_a: assert property (
        $fell(too_long_o) |-> package_present_o)
        else $error("too long cleared without accept");
    long_tach_a: assert property (
        $rose(too_long_o) |-> since_q < 4'hA)
        else $error("too long without belt travel");
    reset_quiet_a: assert property (
        $fell(rst_i) |-> !scan_trigger_o && !package_present_o
            && !irq_o && !too_long_o)
        else $error("outputs active after reset");
    cover property ($rose(scan_trigger_o));
    cover property ($rose(too_long_o));
    cover property ($rose(irq_o));
endmodule

bind ptq_top ptq_checker u_chk (
    .clk_i, .rst_i, .presence_sensor_i, .curtain_blocked_i,
    .curtain_height_i, .tach_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .scan_trigger_o, .package_present_o,
    .too_long_o, .package_height_o, .irq_o
);

// ### verification/ptq_tb_top.sv
// Self-checking bench for the package trigger qualifier
`timescale 1ns/1ps
module ptq_tb_top;
    logic clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic pkg = 1'h0;
    logic act_low = 1'h0;
    logic tach_en = 1'h0;
    logic [15:0] hgt = 16'h012C;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_we_i = 1'h0;
    logic reg_re_i = 1'h0;
    logic pe_w, blk_w, tach_w;
    logic [15:0] hgt_w, package_height_o;
    logic [31:0] reg_rdata_o;
    logic scan_trigger_o, package_present_o, too_long_o, irq_o;
    int n_fail = 0;
    int num_checks = 0;
    int scans = 0;

    always #2.5 clk_i = ~clk_i;

    ptq_sensor_model MODEL (.clk_i, .rst_i, .pkg_i(pkg),
        .act_low_i(act_low), .tach_en_i(tach_en), .hgt_i(hgt),
        .presence_o(pe_w), .blocked_o(blk_w), .tach_o(tach_w),
        .height_o(hgt_w));
    ptq_top DUT (.clk_i, .rst_i, .presence_sensor_i(pe_w),
        .curtain_blocked_i(blk_w), .curtain_height_i(hgt_w),
        .tach_i(tach_w), .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
        .reg_rdata_o, .scan_trigger_o, .package_present_o, .too_long_o,
        .package_height_o, .irq_o);

    always @(posedge clk_i) begin
        if (scan_trigger_o === 1'h1) begin
            scans++;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'h1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'h0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        reg_re_i <= 1'h1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'h0;
        @(negedge clk_i);
        chk(reg_rdata_o, e);
    endtask
    // Belt runs for n tach pulses, then the sensor path settles
    task automatic belt(input int n);
        tach_en <= 1'h1;
        repeat (n) @(posedge tach_w);
        tach_en <= 1'h0;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic show(input int n);
        pkg <= 1'h1;
        repeat (8) @(posedge clk_i);
        belt(n);
    endtask
    task automatic hide;
        pkg <= 1'h0;
        repeat (8) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] rv [8];
        rv = '{32'(ptq_pkg::RST_MODE), 32'(ptq_pkg::RST_RES),
            32'(ptq_pkg::RST_DEBOUNCE), 32'(ptq_pkg::RST_MAX_LEN),
            32'(ptq_pkg::RST_PE_SCAN), 32'(ptq_pkg::RST_LC_SCAN),
            32'(ptq_pkg::RST_LC_OFFSET), 32'(ptq_pkg::RST_MIN_HEIGHT)};
        for (int i = 0; i < 8; i++) begin
            rdchk(8'(4 * i), rv[i]);
        end
        wr(ptq_pkg::ADDR_LC_OFFSET, 32'hFFEC);
        rdchk(ptq_pkg::ADDR_LC_OFFSET, 32'hFFEC);
        wr(ptq_pkg::ADDR_HEIGHT, 32'hFFFF);
        rdchk(ptq_pkg::ADDR_HEIGHT, 32'h0);
        rdchk(8'h3C, 32'h0);
    endtask
    // Debounce of two pulses survives the glitch of a polarity change
    task automatic t_debounce;
        wr(ptq_pkg::ADDR_DEBOUNCE, 32'h14);
        for (int p = 0; p < 2; p++) begin
            wr(ptq_pkg::ADDR_PE_SCAN, 32'(p * 30));
            wr(ptq_pkg::ADDR_CTRL, 32'(p * 4));
            act_low <= p[0];
            repeat (8) @(posedge clk_i);
            scans = 0;
            show(1);
            chk(package_present_o, 1'h0);
            belt(1);
            chk(package_present_o, 1'h1);
            chk(scans, 32'(1 - p));
            belt(2);
            chk(scans, 32'(1 - p));
            rdchk(ptq_pkg::ADDR_STATUS, 32'(3 + 8 * p));
            belt(1);
            chk(scans, 32'h1);
            hide;
            chk(package_present_o, 1'h0);
        end
        show(1);
        hide;
        belt(2);
        chk(package_present_o, 1'h0);
        chk(scans, 32'h1);
        wr(ptq_pkg::ADDR_CTRL, 32'h0);
        act_low <= 1'h0;
        repeat (8) @(posedge clk_i);
        wr(ptq_pkg::ADDR_DEBOUNCE, 32'h0);
        wr(ptq_pkg::ADDR_PE_SCAN, 32'h0);
    endtask
    // Four-inch limit is 40 pulses at the reset resolution
    task automatic t_too_long;
        wr(ptq_pkg::ADDR_MAX_LEN, 32'h190);
        wr(ptq_pkg::ADDR_IRQ_STATUS, 32'hF);
        show(40);
        chk(too_long_o, 1'h0);
        belt(1);
        chk(too_long_o, 1'h1);
        hide;
        chk(too_long_o, 1'h1);
        rdchk(ptq_pkg::ADDR_TOO_LONG_CNT, 32'h1);
        chk(irq_o, 1'h0);
        rdchk(ptq_pkg::ADDR_IRQ_STATUS, 32'h7);
        wr(ptq_pkg::ADDR_IRQ_MASK, 32'h2);
        @(negedge clk_i);
        chk(irq_o, 1'h1);
        wr(ptq_pkg::ADDR_IRQ_STATUS, 32'h2);
        @(negedge clk_i);
        chk(irq_o, 1'h0);
        rdchk(ptq_pkg::ADDR_IRQ_STATUS, 32'h5);
        show(1);
        chk(too_long_o, 1'h0);
        hide;
        rdchk(ptq_pkg::ADDR_TOO_LONG_CNT, 32'h1);
        wr(ptq_pkg::ADDR_MAX_LEN, 32'(ptq_pkg::RST_MAX_LEN));
    endtask
    // Every mode, 2.80 in package, minimum height 5.00 then 0.50
    task automatic t_modes;
        logic [31:0] e;
        logic [31:0] s;
        wr(ptq_pkg::ADDR_LC_SCAN, 32'hA);
        for (int p = 0; p < 2; p++) begin
            wr(ptq_pkg::ADDR_MIN_HEIGHT, (p == 1) ? 32'h32 : 32'h1F4);
            for (int m = 0; m < 4; m++) begin
                wr(ptq_pkg::ADDR_CTRL, 32'(m));
                wr(ptq_pkg::ADDR_IRQ_STATUS, 32'hF);
                scans = 0;
                e = (m == 0) ? 32'h1 : (m == 3) ? 32'h0 : 32'(p);
                s = 32'((m == 1 || m == 2) && p == 0);
                pkg <= 1'h1;
                repeat (8) @(posedge clk_i);
                chk(scans, 32'(m == 0 || (m == 2 && p == 1)));
                belt(3);
                if (m == 1 || m == 2) begin
                    chk(package_height_o, 32'h118);
                end
                hide;
                chk(scans, e);
                s = (m == 3) ? 32'h0 : 32'h1 | (e << 2) | (s << 3);
                rdchk(ptq_pkg::ADDR_IRQ_STATUS, s);
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        t_regs;
        t_debounce;
        t_too_long;
        t_modes;
        close_out;
    end
    // Whole run needs about 1200 clocks
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        close_out;
    end
endmodule
